// ### rtl/atrb_pkg.sv
/*
 Constants for the per-channel trim register bank: register addresses,
 field layouts, reset codes and load-command encoding.
 Assumes a 16-bit serial register port with 7-bit addresses.
*/
package atrb_pkg;
    localparam int          ATRB_AW        = 7;
    localparam int          ATRB_DW        = 16;
    localparam int          ATRB_TW        = 10;
    localparam int          ATRB_NCH       = 4;
    localparam int          ATRB_CHW       = 2;
    localparam logic [6:0]  ADDR_LANE_PICK = 7'h00;
    localparam logic [6:0]  ADDR_LOAD_CMD  = 7'h10;
    localparam logic [6:0]  ADDR_MAILBOX   = 7'h11;
    localparam logic [6:0]  ADDR_STG_OFS   = 7'h20;
    localparam logic [6:0]  ADDR_CUR_OFS   = 7'h21;
    localparam logic [6:0]  ADDR_STG_GAIN  = 7'h22;
    localparam logic [6:0]  ADDR_CUR_GAIN  = 7'h23;
    localparam logic [6:0]  ADDR_STG_PHS   = 7'h24;
    localparam logic [6:0]  ADDR_CUR_PHS   = 7'h25;
    localparam logic [9:0]  TRIM_RST       = 10'h200;
    localparam logic [1:0]  LOAD_GO        = 2'h2;
    localparam logic [1:0]  LOAD_IDLE      = 2'h0;
    // Command fields within the load-command word
    localparam int          CMD_OFS_LSB    = 0;
    localparam int          CMD_GAIN_LSB   = 2;
    localparam int          CMD_PHS_LSB    = 4;
    localparam int          XFER_CYCLES    = 4;
    localparam logic [2:0]  XFER_LAST      = 3'(XFER_CYCLES - 1);
    typedef enum logic [1:0] {ATRB_IDLE, ATRB_GAIN, ATRB_OFS, ATRB_PHS} atrb_state_t;
endpackage

// ### rtl/atrb_bank.sv
/*
 Four-channel trim register bank: staged and current offset, gain and phase,
 lane pick, load-command and busy mailbox, reached over a simple register port.
 Assumes the register port is synchronous to MCLK_I (the serial decoder sits on
 the same clock) and write/read strobes are single-cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module atrb_bank
    import atrb_pkg::*;
(
    input  wire logic                MCLK_I,
    input  wire logic                RSTN_I,
    input  wire logic                WR_I,
    input  wire logic                RD_I,
    input  wire logic [ATRB_AW-1:0]  ADDR_I,
    input  wire logic [ATRB_DW-1:0]  WDATA_I,
    output logic      [ATRB_DW-1:0]  RDATA_O,
    output logic                     RVALID_O,
    output logic      [ATRB_NCH*ATRB_TW-1:0] OFS_TRIM_O,
    output logic      [ATRB_NCH*ATRB_TW-1:0] GAIN_TRIM_O,
    output logic      [ATRB_NCH*ATRB_TW-1:0] PHS_TRIM_O,
    output logic      [ATRB_NCH-1:0]  BUSY_O
);
    logic [ATRB_CHW-1:0] lane_ff;
    logic [ATRB_TW-1:0]  stg_ofs_ff  [ATRB_NCH];
    logic [ATRB_TW-1:0]  stg_gain_ff [ATRB_NCH];
    logic [ATRB_TW-1:0]  stg_phs_ff  [ATRB_NCH];
    logic [ATRB_TW-1:0]  cur_ofs_ff  [ATRB_NCH];
    logic [ATRB_TW-1:0]  cur_gain_ff [ATRB_NCH];
    logic [ATRB_TW-1:0]  cur_phs_ff  [ATRB_NCH];
    logic [5:0]          cmd_ff      [ATRB_NCH];
    logic [ATRB_DW-1:0]  rdata_ff;
    logic                rvalid_ff;

    wire [ATRB_TW-1:0] wr_trim = WDATA_I[ATRB_TW-1:0];
    wire wr_lane  = WR_I && (ADDR_I == ADDR_LANE_PICK);
    wire wr_cmd   = WR_I && (ADDR_I == ADDR_LOAD_CMD);
    wire wr_sofs  = WR_I && (ADDR_I == ADDR_STG_OFS);
    wire wr_sgain = WR_I && (ADDR_I == ADDR_STG_GAIN);
    wire wr_sphs  = WR_I && (ADDR_I == ADDR_STG_PHS);

    genvar ch;
    generate
        for (ch = 0; ch < ATRB_NCH; ch++)
        begin : g_ch
            atrb_state_t st_ff;
            atrb_state_t nxt_st;
            logic [2:0]  cnt_ff;
            logic [2:0]  nxt_cnt;
            logic        go_ofs;
            logic        go_gain;
            logic        go_phs;
            logic        fin_ofs;
            logic        fin_gain;
            logic        fin_phs;
            logic        pend_ofs_ff;
            logic        pend_gain_ff;
            logic        pend_phs_ff;
            logic        nxt_pend_ofs;
            logic        nxt_pend_gain;
            logic        nxt_pend_phs;
            wire         sel      = (lane_ff == ATRB_CHW'(ch));
            wire         step_end = (cnt_ff == XFER_LAST);
            // only code 10 starts a transfer
            assign go_ofs  = wr_cmd && sel && (WDATA_I[CMD_OFS_LSB +: 2] == LOAD_GO);
            assign go_gain = wr_cmd && sel && (WDATA_I[CMD_GAIN_LSB +: 2] == LOAD_GO);
            assign go_phs  = wr_cmd && sel && (WDATA_I[CMD_PHS_LSB +: 2] == LOAD_GO);
            assign fin_ofs  = (st_ff == ATRB_OFS)  && step_end;
            assign fin_gain = (st_ff == ATRB_GAIN) && step_end;
            assign fin_phs  = (st_ff == ATRB_PHS)  && step_end;
            // New orders win over completion clears
            assign nxt_pend_ofs  = go_ofs  || (pend_ofs_ff  && !fin_ofs);
            assign nxt_pend_gain = go_gain || (pend_gain_ff && !fin_gain);
            assign nxt_pend_phs  = go_phs  || (pend_phs_ff  && !fin_phs);
            // Step counter restarts whenever the state moves
            assign nxt_cnt = (nxt_st != st_ff || st_ff == ATRB_IDLE) ? 3'h0 : cnt_ff + 3'h1;

            always_comb
            begin
                nxt_st = st_ff;
                if (st_ff == ATRB_IDLE || step_end)
                begin
                    if (pend_gain_ff && st_ff != ATRB_GAIN)
                        nxt_st = ATRB_GAIN;
                    else if (pend_ofs_ff && st_ff != ATRB_OFS)
                        nxt_st = ATRB_OFS;
                    else if (pend_phs_ff && st_ff != ATRB_PHS)
                        nxt_st = ATRB_PHS;
                    else
                        nxt_st = ATRB_IDLE;
                end
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    st_ff        <= ATRB_IDLE;
                    cnt_ff       <= 3'h0;
                    pend_ofs_ff  <= 1'b0;
                    pend_gain_ff <= 1'b0;
                    pend_phs_ff  <= 1'b0;
                end
                else
                begin
                    st_ff        <= nxt_st;
                    cnt_ff       <= nxt_cnt;
                    pend_ofs_ff  <= nxt_pend_ofs;
                    pend_gain_ff <= nxt_pend_gain;
                    pend_phs_ff  <= nxt_pend_phs;
                end
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    stg_ofs_ff[ch]  <= TRIM_RST;
                    stg_gain_ff[ch] <= TRIM_RST;
                    stg_phs_ff[ch]  <= TRIM_RST;
                end
                else
                begin
                    if (wr_sofs && sel)
                        stg_ofs_ff[ch] <= wr_trim;
                    if (wr_sgain && sel)
                        stg_gain_ff[ch] <= wr_trim;
                    if (wr_sphs && sel)
                        stg_phs_ff[ch] <= wr_trim;
                end
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                    cmd_ff[ch] <= 6'h00;
                else if (wr_cmd && sel)
                    cmd_ff[ch] <= WDATA_I[5:0];
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    cur_ofs_ff[ch]  <= TRIM_RST;
                    cur_gain_ff[ch] <= TRIM_RST;
                    cur_phs_ff[ch]  <= TRIM_RST;
                end
                else
                begin
                    if (fin_gain)
                        cur_gain_ff[ch] <= stg_gain_ff[ch];
                    if (fin_ofs)
                        cur_ofs_ff[ch] <= stg_ofs_ff[ch];
                    if (fin_phs)
                        cur_phs_ff[ch] <= stg_phs_ff[ch];
                end
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                    BUSY_O[ch] <= 1'b0;
                else
                    BUSY_O[ch] <= nxt_pend_ofs || nxt_pend_gain || nxt_pend_phs;
            end

            always_ff @(posedge MCLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    OFS_TRIM_O[ch*ATRB_TW +: ATRB_TW]  <= TRIM_RST;
                    GAIN_TRIM_O[ch*ATRB_TW +: ATRB_TW] <= TRIM_RST;
                    PHS_TRIM_O[ch*ATRB_TW +: ATRB_TW]  <= TRIM_RST;
                end
                else
                begin
                    OFS_TRIM_O[ch*ATRB_TW +: ATRB_TW]  <= cur_ofs_ff[ch];
                    GAIN_TRIM_O[ch*ATRB_TW +: ATRB_TW] <= cur_gain_ff[ch];
                    PHS_TRIM_O[ch*ATRB_TW +: ATRB_TW]  <= cur_phs_ff[ch];
                end
            end
        end
    endgenerate

    wire [ATRB_DW-1:0] rd_mux =
        (ADDR_I == ADDR_LANE_PICK) ? {14'h0000, lane_ff} :
        (ADDR_I == ADDR_LOAD_CMD)  ? {10'h000, cmd_ff[lane_ff]} :
        (ADDR_I == ADDR_MAILBOX)   ? {15'h0000, BUSY_O[lane_ff]} :
        (ADDR_I == ADDR_STG_OFS)   ? {6'h00, stg_ofs_ff[lane_ff]} :
        (ADDR_I == ADDR_CUR_OFS)   ? {6'h00, cur_ofs_ff[lane_ff]} :
        (ADDR_I == ADDR_STG_GAIN)  ? {6'h00, stg_gain_ff[lane_ff]} :
        (ADDR_I == ADDR_CUR_GAIN)  ? {6'h00, cur_gain_ff[lane_ff]} :
        (ADDR_I == ADDR_STG_PHS)   ? {6'h00, stg_phs_ff[lane_ff]} :
        (ADDR_I == ADDR_CUR_PHS)   ? {6'h00, cur_phs_ff[lane_ff]} : 16'h0000;

    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lane_ff   <= 2'h0;
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            if (wr_lane)
                lane_ff <= WDATA_I[ATRB_CHW-1:0];
            rvalid_ff <= RD_I;
            if (RD_I)
                rdata_ff <= rd_mux;
        end
    end

    assign RDATA_O  = rdata_ff;
    assign RVALID_O = rvalid_ff;
endmodule
`default_nettype wire

// ### tb/atrb_bank_sva.sv
/*
 Port checker for atrb_bank: read answer, loose bits, busy and trim timing.
 Assumes single-cycle strobes, all on MCLK_I.
*/
`timescale 1ns/100ps
`default_nettype none
module atrb_bank_sva
    import atrb_pkg::*;
(
    input wire logic                        MCLK_I,
    input wire logic                        RSTN_I,
    input wire logic                        WR_I,
    input wire logic                        RD_I,
    input wire logic [ATRB_AW-1:0]          ADDR_I,
    input wire logic [ATRB_DW-1:0]          WDATA_I,
    input wire logic [ATRB_DW-1:0]          RDATA_O,
    input wire logic                        RVALID_O,
    input wire logic [ATRB_NCH*ATRB_TW-1:0] OFS_TRIM_O,
    input wire logic [ATRB_NCH*ATRB_TW-1:0] GAIN_TRIM_O,
    input wire logic [ATRB_NCH*ATRB_TW-1:0] PHS_TRIM_O,
    input wire logic [ATRB_NCH-1:0]         BUSY_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    wire go_w  = WR_I && ADDR_I == ADDR_LOAD_CMD;
    wire any_w = WDATA_I[1:0] == LOAD_GO || WDATA_I[3:2] == LOAD_GO || WDATA_I[5:4] == LOAD_GO;
    sequence s_hold; BUSY_O[0] [*4]; endsequence
    sequence s_drop; BUSY_O[0] ##[1:40] !BUSY_O[0]; endsequence
    property p_rvalid; RD_I |=> RVALID_O; endproperty
    property p_upper; RVALID_O |-> RDATA_O[15:10] == 6'h00; endproperty
    // Trims move only around a transfer
    property p_ofs; !$stable(OFS_TRIM_O) |-> |{BUSY_O, $past(BUSY_O), $past(BUSY_O, 2)}; endproperty
    property p_gain; !$stable(GAIN_TRIM_O) |-> |{BUSY_O, $past(BUSY_O), $past(BUSY_O, 2)}; endproperty
    property p_phs; !$stable(PHS_TRIM_O) |-> |{BUSY_O, $past(BUSY_O), $past(BUSY_O, 2)}; endproperty
    property p_busy_rise; go_w && WDATA_I[3:2] == LOAD_GO |=> BUSY_O != 4'h0; endproperty
    property p_idle; go_w && !any_w && BUSY_O == 4'h0 && !$past(go_w) |=> BUSY_O == 4'h0; endproperty
    property p_busy_len; $rose(BUSY_O[0]) |-> s_hold ##0 s_drop; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_upper: assert property (p_upper) else $error("upper bits set");
    a_ofs: assert property (p_ofs) else $error("offset moved while idle");
    a_gain: assert property (p_gain) else $error("gain moved while idle");
    a_phs: assert property (p_phs) else $error("phase moved while idle");
    a_busy_rise: assert property (p_busy_rise) else $error("busy missing");
    a_idle: assert property (p_idle) else $error("idle code started work");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule
`default_nettype wire

// ### tb/atrb_host.sv
/*
 Host model driving the register port; notes expected read data.
 Assumes the caller enters tasks just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module atrb_host
    import atrb_pkg::*;
(
    input  wire logic               clk_i,
    output logic                    wr_o,
    output logic                    rd_o,
    output logic [ATRB_AW-1:0]      addr_o,
    output logic [ATRB_DW-1:0]      wdata_o
);
    logic [ATRB_DW-1:0] exp_q [$];
    initial
    begin
        wr_o = 0; rd_o = 0; addr_o = '0; wdata_o = '0;
    end
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        wr_o = 1; rd_o = 0; addr_o = a; wdata_o = d;
        @(posedge clk_i); #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        wr_o = 0; rd_o = 1; addr_o = a; wdata_o = ~wdata_o;
        exp_q.push_back(e);
        @(posedge clk_i); #1;
    endtask
    // Released lines never keep the last value
    task automatic idle();
        wr_o = 0; rd_o = 0; addr_o = ~addr_o; wdata_o = ~wdata_o;
        @(posedge clk_i); #1;
    endtask
endmodule
`default_nettype wire

// ### tb/atrb_bank_tb_top.sv
/*
 Self-checking bench for atrb_bank: resets, staging, loads, order.
 Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module atrb_bank_tb_top;
    import atrb_pkg::*;
    logic clk, rstn, wr, rd, rvalid;
    logic [6:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [39:0] ofs, gain, phs;
    logic [3:0] busy;
    logic [9:0] stg [4][3];
    int n_errors = 0, check_count = 0, seed = 54, c, f, k, tg, to, tp;
    atrb_host host_u (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    atrb_bank dut_u (.MCLK_I(clk), .RSTN_I(rstn), .WR_I(wr), .RD_I(rd), .ADDR_I(addr), .WDATA_I(wdata),
        .RDATA_O(rdata), .RVALID_O(rvalid), .OFS_TRIM_O(ofs), .GAIN_TRIM_O(gain), .PHS_TRIM_O(phs), .BUSY_O(busy));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) if (rvalid === 1'b1) chk(rdata, host_u.exp_q.pop_front());
    initial
    begin
        rstn = 0;
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        for (c = 0; c < 4; c++)
        begin
            host_u.wr(ADDR_LANE_PICK, 16'(c));
            for (f = 0; f < 6; f++) host_u.rd(ADDR_STG_OFS + 7'(f), 16'h0200);
            for (f = 0; f < 3; f++)
            begin
                v = 16'($random(seed));
                if (v[9:0] == TRIM_RST) v = v ^ 16'h0001;
                stg[c][f] = v[9:0];
                host_u.wr(ADDR_STG_OFS + 7'(2 * f), v);
            end
            for (f = 0; f < 3; f++) host_u.wr(ADDR_CUR_OFS + 7'(2 * f), 16'h0155);
            for (f = 0; f < 3; f++)
            begin
                host_u.rd(ADDR_STG_OFS + 7'(2 * f), {6'h00, stg[c][f]});
                host_u.rd(ADDR_CUR_OFS + 7'(2 * f), 16'h0200);
            end
            host_u.wr(ADDR_LOAD_CMD, 16'h0015);
            host_u.wr(ADDR_LOAD_CMD, 16'h003F);
            host_u.rd(ADDR_CUR_GAIN, 16'h0200);
            host_u.wr(ADDR_LOAD_CMD, 16'h002A);
            host_u.idle();
            tg = 0; to = 0; tp = 0;
            for (k = 0; k < 60 && busy !== 4'h0; k++)
            begin
                if (gain[c*10+:10] !== stg[c][1]) tg = k;
                if (ofs[c*10+:10] !== stg[c][0]) to = k;
                if (phs[c*10+:10] !== stg[c][2]) tp = k;
                @(posedge clk); #1;
            end
            if (k == 60)
            begin
                n_errors++;
            end
            repeat (2) host_u.idle();
            chk(16'(tg < to && to < tp), 16'h0001);
            chk(16'(ofs[c*10+:10]), 16'(stg[c][0]));
            chk(16'(gain[c*10+:10]), 16'(stg[c][1]));
            chk(16'(phs[c*10+:10]), 16'(stg[c][2]));
            for (f = 0; f < 3; f++) host_u.rd(ADDR_CUR_OFS + 7'(2 * f), {6'h00, stg[c][f]});
            host_u.rd(ADDR_LOAD_CMD, 16'h002A);
            host_u.rd(ADDR_MAILBOX, 16'h0000);
        end
        host_u.rd(7'h7F, 16'h0000);
        repeat (3) host_u.idle();
        // Mid-run reset must bring lane 0 staged and current trims back to neutral
        rstn = 0;
        repeat (2) @(posedge clk);
        #1 rstn = 1;
        host_u.rd(ADDR_LANE_PICK, 16'h0000);
        for (f = 0; f < 6; f++) host_u.rd(ADDR_STG_OFS + 7'(f), 16'h0200);
        repeat (3) host_u.idle();
        // Every queued read must have been answered
        chk(16'(host_u.exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule
bind atrb_bank atrb_bank_sva chk_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .OFS_TRIM_O(OFS_TRIM_O),
    .GAIN_TRIM_O(GAIN_TRIM_O), .PHS_TRIM_O(PHS_TRIM_O), .BUSY_O(BUSY_O));
`default_nettype wire
